// ### core/drc_ctrl.sv
// Host-side controller driving strobes, address and data of a 64K x 1 dram
`default_nettype none
`include "drc_cfg.svh"
module drc_ctrl #(
  parameter int unsigned PAUSE_CYC = `DRC_CYC_MIN(`DRC_T_PAUSE_NS),
  parameter int unsigned REFI_CYC  = `DRC_CYC_MAX(`DRC_T_REFI_NS),
  parameter int unsigned IDLE_CYC  = `DRC_CYC_MAX(`DRC_T_IDLE_NS),
  parameter int unsigned RASMX_CYC = `DRC_CYC_MAX(`DRC_T_RAS_MAX_NS)
) (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            req_valid,
  output logic                 req_ready,
  input  wire drc_pkg::drc_op_t req_op,
  input  wire logic [7:0]      req_row,
  input  wire logic [7:0]      req_col,
  input  wire logic            req_wdata,
  input  wire logic            req_page,
  output logic                 rsp_valid,
  output logic                 rsp_rdata,
  output logic                 init_done,
  output logic                 row_strobe_n,
  output logic                 column_strobe_n,
  output logic                 write_enable_n,
  output logic [7:0]           mem_addr,
  output logic                 mem_din,
  input  wire logic            mem_dout
);
  localparam int unsigned RAH_CYC = `DRC_CYC_MIN(`DRC_T_RAH_NS);
  localparam int unsigned CAC_CYC = `DRC_CYC_MIN(`DRC_T_RAC_NS);
  localparam int unsigned CAS_CYC = `DRC_CYC_MIN(`DRC_T_CAS_NS);
  localparam int unsigned CWL_CYC = `DRC_CYC_MIN(`DRC_T_CWL_NS);
  localparam int unsigned RWL_CYC = `DRC_CYC_MIN(`DRC_T_RWL_NS);
  localparam int unsigned RP_CYC  = `DRC_CYC_MIN(`DRC_T_RP_NS);
  localparam int unsigned CP_CYC  = `DRC_CYC_MIN(`DRC_T_CP_NS);
  localparam int unsigned RAS_CYC = `DRC_CYC_MIN(`DRC_T_RAS_NS);
  // Page guard leaves room for one more column access and the write lead
  localparam int unsigned PAGE_GUARD = CAC_CYC + CWL_CYC + CP_CYC + 4;

  ////////////////////////////////////////////////////////////////////////////
  // State
  drc_pkg::drc_state_t st_q, st_d;
  drc_pkg::drc_op_t    op_q, op_d;
  logic       ras_n_q, ras_n_d, cas_n_q, cas_n_d, we_n_q, we_n_d;
  logic [7:0] addr_q, addr_d;
  logic       din_q, din_d, rdata_q, rdata_d, rvld_q, rvld_d;
  logic       refr_q, refr_d, init_q, init_d;
  logic [6:0] rrow_q, rrow_d;
  logic [3:0] wake_q, wake_d;
  logic [7:0] row_q, row_d;
  logic [15:0] ref_cnt_q, ref_cnt_d;
  logic [17:0] idle_cnt_q, idle_cnt_d;
  logic [11:0] ras_age_q, ras_age_d;
  logic       ref_due;
  logic       t_load, t_done;
  logic [15:0] t_val;
  logic [7:0] req_col_q, req_col_d;
  logic       pause_arm_q;

  drc_timer #(.W(16)) u_timer (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .load    (t_load),
    .value   (t_val),
    .done    (t_done)
  );

  assign ref_due   = (ref_cnt_q == '0);
  // Page hit: same row, row still open and far from its maximum active time
  logic page_ok;
  assign page_ok = req_valid && req_page && !refr_q && (req_row == row_q)
                   && (32'(ras_age_q) + PAGE_GUARD < RASMX_CYC);
  // Ready in idle, or at the end of column precharge when a page hit is taken
  assign req_ready = ((st_q == drc_pkg::DRC_ST_IDLE) && init_q && !ref_due
                      && (idle_cnt_q != '0))
                     || ((st_q == drc_pkg::DRC_ST_COLPRE) && t_done && page_ok);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the cycle sequencer
  always_comb begin
    st_d = st_q;  op_d = op_q;
    ras_n_d = ras_n_q;  cas_n_d = cas_n_q;  we_n_d = we_n_q;
    addr_d = addr_q;  din_d = din_q;  rdata_d = rdata_q;  rvld_d = 1'b0;
    refr_d = refr_q;  init_d = init_q;  rrow_d = rrow_q;  wake_d = wake_q;
    row_d = row_q;
    t_load = 1'b0;  t_val = '0;
    ref_cnt_d = (ref_cnt_q != '0) ? ref_cnt_q - 16'h0001 : ref_cnt_q;
    idle_cnt_d = (idle_cnt_q != '0) ? idle_cnt_q - 18'h0_0001 : idle_cnt_q;
    ras_age_d = ras_n_q ? 12'h000 : ras_age_q + 12'h001;
    case (st_q)
      drc_pkg::DRC_ST_PAUSE: begin
        // Power-up pause loaded once, straight after reset
        if (pause_arm_q) begin
          t_load = 1'b1;  t_val = 16'(PAUSE_CYC);
        end else if (t_done) begin
          st_d = drc_pkg::DRC_ST_WAKE;  wake_d = 4'h0;
        end
      end
      drc_pkg::DRC_ST_WAKE: begin
        // Row-strobe-only cycles with column strobe high
        if (t_done) begin
          if (wake_q == 4'(`DRC_WAKE_CYCLES)) begin
            st_d = drc_pkg::DRC_ST_IDLE;  init_d = 1'b1;
            idle_cnt_d = 18'(IDLE_CYC);
          end else begin
            st_d = drc_pkg::DRC_ST_ROW;  refr_d = 1'b1;
            addr_d = {1'b0, rrow_q};
          end
        end
      end
      drc_pkg::DRC_ST_IDLE: begin
        if (idle_cnt_q == '0) begin
          st_d = drc_pkg::DRC_ST_WAKE;  wake_d = 4'h0;  init_d = 1'b0;
        end else if (ref_due) begin
          // Strobe-only refresh of the next counted row
          st_d = drc_pkg::DRC_ST_ROW;  refr_d = 1'b1;  addr_d = {1'b0, rrow_q};
        end else if (req_valid) begin
          st_d = drc_pkg::DRC_ST_ROW;  refr_d = 1'b0;  op_d = req_op;
          addr_d = req_row;  row_d = req_row;  din_d = req_wdata;
          we_n_d = (req_op != drc_pkg::DRC_OP_WRITE);
        end
      end
      drc_pkg::DRC_ST_ROW: begin
        // Address stood a cycle already; now the row strobe falls
        ras_n_d = 1'b0;  st_d = drc_pkg::DRC_ST_RAH;
        t_load = 1'b1;  t_val = 16'(RAH_CYC);
      end
      drc_pkg::DRC_ST_RAH: begin
        if (t_done) begin
          if (refr_q) begin
            st_d = drc_pkg::DRC_ST_RASACT;
            t_load = 1'b1;  t_val = 16'(RAS_CYC);
          end else begin
            // Switch to column address after the row hold
            addr_d = req_col_q;  st_d = drc_pkg::DRC_ST_COL;
          end
        end
      end
      drc_pkg::DRC_ST_COL: begin
        // Column strobe falls with write enable already settled
        cas_n_d = 1'b0;  st_d = drc_pkg::DRC_ST_WRITE;
        t_load = 1'b1;
        t_val = 16'(CAC_CYC > CAS_CYC ? CAC_CYC : CAS_CYC);
      end
      drc_pkg::DRC_ST_WRITE: begin
        if (t_done) begin
          if (op_q == drc_pkg::DRC_OP_RMW && we_n_q) begin
            // Read first, then write enable falls at the same cell
            rdata_d = mem_dout;  rvld_d = 1'b1;  we_n_d = 1'b0;
            t_load = 1'b1;
            t_val = 16'(CWL_CYC > RWL_CYC ? CWL_CYC : RWL_CYC);
          end else begin
            if (op_q == drc_pkg::DRC_OP_READ) begin
              rdata_d = mem_dout;  rvld_d = 1'b1;
            end
            // Release column strobe and raise write enable in the same cycle, for every operation
            cas_n_d = 1'b1;  we_n_d = 1'b1;  st_d = drc_pkg::DRC_ST_COLPRE;
            t_load = 1'b1;  t_val = 16'(CP_CYC);
          end
        end
      end
      drc_pkg::DRC_ST_COLPRE: begin
        if (t_done) begin
          if (page_ok) begin
            // Next page column with any operation type
            op_d = req_op;  addr_d = req_col;  din_d = req_wdata;
            we_n_d = (req_op != drc_pkg::DRC_OP_WRITE);
            st_d = drc_pkg::DRC_ST_COL;
          end else if (32'(ras_age_q) >= RAS_CYC) begin
            ras_n_d = 1'b1;  st_d = drc_pkg::DRC_ST_PRE;
            t_load = 1'b1;  t_val = 16'(RP_CYC);
          end
        end
      end
      drc_pkg::DRC_ST_RASACT: begin
        if (t_done) begin
          ras_n_d = 1'b1;  st_d = drc_pkg::DRC_ST_PRE;
          t_load = 1'b1;  t_val = 16'(RP_CYC);
          rrow_d = rrow_q + 7'h01;
          if (!init_q) begin
            wake_d = wake_q + 4'h1;
          end else begin
            ref_cnt_d = 16'(REFI_CYC);
          end
        end
      end
      drc_pkg::DRC_ST_PRE: begin
        if (t_done) begin
          refr_d = 1'b0;
          if (!init_q) begin
            st_d = drc_pkg::DRC_ST_WAKE;
          end else begin
            st_d = drc_pkg::DRC_ST_IDLE;  idle_cnt_d = 18'(IDLE_CYC);
          end
        end
      end
      default: st_d = drc_pkg::DRC_ST_PAUSE;
    endcase
    if (st_q == drc_pkg::DRC_ST_IDLE && req_valid && req_ready) begin
      req_col_d = req_col;
    end else begin
      req_col_d = req_col_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers of the sequencer
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= drc_pkg::DRC_ST_PAUSE;  op_q <= drc_pkg::DRC_OP_READ;
      ras_n_q <= 1'b1;  cas_n_q <= 1'b1;  we_n_q <= 1'b1;
      addr_q <= 8'h00;  din_q <= 1'b0;  rdata_q <= 1'b0;  rvld_q <= 1'b0;
      refr_q <= 1'b0;  init_q <= 1'b0;  rrow_q <= 7'h00;  wake_q <= 4'h0;
      row_q <= 8'h00;  ref_cnt_q <= 16'(REFI_CYC);  idle_cnt_q <= 18'h0_0000;
      ras_age_q <= 12'h000;  req_col_q <= 8'h00;
    end else begin
      st_q <= st_d;  op_q <= op_d;
      ras_n_q <= ras_n_d;  cas_n_q <= cas_n_d;  we_n_q <= we_n_d;
      addr_q <= addr_d;  din_q <= din_d;  rdata_q <= rdata_d;  rvld_q <= rvld_d;
      refr_q <= refr_d;  init_q <= init_d;  rrow_q <= rrow_d;  wake_q <= wake_d;
      row_q <= row_d;  ref_cnt_q <= ref_cnt_d;  idle_cnt_q <= idle_cnt_d;
      ras_age_q <= ras_age_d;  req_col_q <= req_col_d;
    end
  end

  // Power-up pause is loaded into the shared timer straight after reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pause_arm_q <= 1'b1;
    end else begin
      pause_arm_q <= 1'b0;
    end
  end

  assign row_strobe_n    = ras_n_q;
  assign column_strobe_n = cas_n_q;
  assign write_enable_n  = we_n_q;
  assign mem_addr        = addr_q;
  assign mem_din         = din_q;
  assign rsp_valid       = rvld_q;
  assign rsp_rdata       = rdata_q;
  assign init_done       = init_q;
endmodule
`default_nettype wire

// ### core/drc_cfg.svh
// Timing constants and field layout for the dram cycle controller
`ifndef DRC_CFG_SVH
`define DRC_CFG_SVH
`define DRC_CLK_PERIOD_PS       8000
`define DRC_T_RAC_NS            120
`define DRC_T_CAC_NS            65
`define DRC_T_RP_NS             90
`define DRC_T_RAS_NS            120
`define DRC_T_CAS_NS            65
`define DRC_T_RAH_NS            20
`define DRC_T_CWL_NS            40
`define DRC_T_RWL_NS            40
`define DRC_T_CP_NS             45
`define DRC_T_RAS_MAX_NS        10000
`define DRC_T_REFI_NS           15600
`define DRC_T_IDLE_NS           2000000
`define DRC_T_PAUSE_NS          100000
`define DRC_WAKE_CYCLES         8
`define DRC_ROW_BITS            8
`define DRC_COL_BITS            8
`define DRC_REF_ROWS            128
// Least times round up, longest times round down
`define DRC_CYC_MIN(ns) ((((ns) * 1000) + `DRC_CLK_PERIOD_PS - 1) / `DRC_CLK_PERIOD_PS)
`define DRC_CYC_MAX(ns) (((ns) * 1000) / `DRC_CLK_PERIOD_PS)
`endif

// ### core/drc_pkg.sv
// Types for the dram cycle controller
`default_nettype none
package drc_pkg;
  typedef enum logic [9:0] {
    DRC_ST_PAUSE  = 10'b00_0000_0001,
    DRC_ST_IDLE   = 10'b00_0000_0010,
    DRC_ST_ROW    = 10'b00_0000_0100,
    DRC_ST_RAH    = 10'b00_0000_1000,
    DRC_ST_COL    = 10'b00_0001_0000,
    DRC_ST_WRITE  = 10'b00_0010_0000,
    DRC_ST_COLPRE = 10'b00_0100_0000,
    DRC_ST_RASACT = 10'b00_1000_0000,
    DRC_ST_PRE    = 10'b01_0000_0000,
    DRC_ST_WAKE   = 10'b10_0000_0000
  } drc_state_t;
  typedef enum logic [1:0] {
    DRC_OP_READ  = 2'h0,
    DRC_OP_WRITE = 2'h1,
    DRC_OP_RMW   = 2'h2
  } drc_op_t;
endpackage
`default_nettype wire

// ### core/drc_timer.sv
// Loadable down counter used for every strobe timing interval except the row active age kept in ras_age_q
`default_nettype none
module drc_timer #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  // Next count: load wins over counting
  always_comb begin
    cnt_d = cnt_q;
    if (load) begin
      cnt_d = value;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - W'(1);
    end
  end

  // Counter register
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Done looks at the count only, so a caller may load on done without a loop
  assign done = (cnt_q == '0);
endmodule
`default_nettype wire

// ### tb/drc_ctrl_asserts.sv
// Pin protocol checker for the dram cycle controller
`default_nettype none
module drc_ctrl_asserts #(
  parameter int unsigned RASMX_CYC = 300
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       init_done,
  input wire logic       row_strobe_n,
  input wire logic       column_strobe_n,
  input wire logic       write_enable_n,
  input wire logic [7:0] mem_addr,
  input wire logic       mem_din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic [15:0] cas_q;
  logic [3:0]  wake_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  // Strobe interval counters; precharge starts full so the first cycle is legal
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      lo_q   <= 16'h0000;
      hi_q   <= 16'h0100;
      cas_q  <= 16'h0000;
      wake_q <= 4'h0;
    end else begin
      lo_q   <= row_strobe_n ? 16'h0000 : lo_q + 16'h0001;
      hi_q   <= row_strobe_n ? hi_q + 16'h0001 : 16'h0000;
      cas_q  <= column_strobe_n ? 16'h0000 : cas_q + 16'h0001;
      wake_q <= ($fell(row_strobe_n) && wake_q != 4'hf) ? wake_q + 4'h1 : wake_q;
    end
  end
  sequence ras_open;
    $fell(row_strobe_n) ##1 !row_strobe_n;
  endsequence
  sequence both_low;
    !write_enable_n && !column_strobe_n;
  endsequence
  // Write starts once write enable and column strobe are both low
  sequence write_open;
    $rose(!write_enable_n && !column_strobe_n);
  endsequence
  sequence strobes_low;
    !row_strobe_n && !column_strobe_n;
  endsequence
  chk_row_hold: assert property (ras_open |-> $stable(mem_addr) [*2])
    else $error("row address moved in hold");
  chk_col_start: assert property ($fell(column_strobe_n) |-> !row_strobe_n && lo_q >= 16'h0003)
    else $error("column strobe too early");
  chk_row_width: assert property ($rose(row_strobe_n) |-> lo_q >= 16'h000f)
    else $error("row strobe too short");
  chk_row_pre: assert property ($fell(row_strobe_n) |-> hi_q >= 16'h000c)
    else $error("row precharge too short");
  chk_col_width: assert property ($rose(column_strobe_n) |-> cas_q >= 16'h0009)
    else $error("column strobe too short");
  chk_col_release: assert property ($rose(row_strobe_n) |-> ##[0:1] column_strobe_n)
    else $error("column strobe left low");
  chk_write_lead: assert property (write_open |-> strobes_low [*5])
    else $error("strobes ended before write lead");
  chk_din_held: assert property (both_low ##1 both_low |-> $stable(mem_din))
    else $error("data in moved while latched");
  chk_page_limit: assert property (!row_strobe_n |-> lo_q < RASMX_CYC)
    else $error("row strobe held too long");
  chk_wake_count: assert property ($rose(init_done) |-> wake_q >= 4'h8)
    else $error("ready before wake cycles");
endmodule
bind drc_ctrl drc_ctrl_asserts #(
  .RASMX_CYC (RASMX_CYC)
) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .init_done(init_done),
  .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
  .write_enable_n(write_enable_n), .mem_addr(mem_addr), .mem_din(mem_din)
);
`default_nettype wire

// ### tb/drc_dram_model.sv
// Behavioural 64K x 1 dram answering the controller strobes
`default_nettype none
module drc_dram_model (
  input  wire logic       row_strobe_n,
  input  wire logic       column_strobe_n,
  input  wire logic       write_enable_n,
  input  wire logic [7:0] mem_addr,
  input  wire logic       mem_din,
  output logic            mem_dout
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        cell_q [65536];
  logic [7:0]  row_q;
  logic [15:0] adr_q;
  logic        rd_q = 1'b0;
  logic        wr_q = 1'b0;
  logic        rac_q = 1'b0;
  logic        cac_q = 1'b0;
  logic        junk_q = 1'b0;
  // Released output flips so a stale level never passes for data
  always #3 junk_q = ~junk_q;
  // Row latch, sampled 1ns late to sit inside the address hold
  always @(negedge row_strobe_n) begin
    #1;
    row_q = mem_addr;
    rac_q = 1'b0;
    #119 rac_q = 1'b1;
  end
  // Column ignored without row; write enable low means early write
  always @(negedge column_strobe_n) begin
    #1;
    if (!row_strobe_n) begin
      adr_q = {row_q, mem_addr};
      rd_q = write_enable_n;
      wr_q = !write_enable_n;
      cac_q = 1'b0;
      if (!write_enable_n) cell_q[adr_q] = mem_din;
      #64 cac_q = 1'b1;
    end
  end
  // Late write edge takes data
  always @(negedge write_enable_n) begin
    #1;
    if (!row_strobe_n && !column_strobe_n) begin
      cell_q[adr_q] = mem_din;
      wr_q = 1'b1;
    end
  end
  // Data only after both access times and while column low
  assign mem_dout = (!column_strobe_n && rd_q && !wr_q && rac_q && cac_q) ?
                    cell_q[adr_q] : junk_q;
endmodule
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the dram cycle controller
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned REFI = 400;
  localparam logic [7:0] ROWS [4] = '{8'h00, 8'hff, 8'h5a, 8'h01};
  localparam logic [7:0] COLS [4] = '{8'hff, 8'h00, 8'ha5, 8'h80};
  logic             clk_sys, rst_n, req_valid, req_ready, req_wdata, req_page;
  logic             rsp_valid, rsp_rdata, init_done, mem_din, mem_dout, rd;
  logic             row_strobe_n, column_strobe_n, write_enable_n;
  logic [7:0]       req_row, req_col, mem_addr;
  drc_pkg::drc_op_t req_op;
  int               num_errors = 0;
  int               cmp_count = 0;
  int               ras_up = 0;
  drc_ctrl #(.PAUSE_CYC(20), .REFI_CYC(REFI), .IDLE_CYC(4000), .RASMX_CYC(300)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .req_row(req_row), .req_col(req_col), .req_wdata(req_wdata),
    .req_page(req_page), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .init_done(init_done), .row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_enable_n(write_enable_n), .mem_addr(mem_addr), .mem_din(mem_din),
    .mem_dout(mem_dout));
  drc_dram_model u_mem (.row_strobe_n(row_strobe_n), .column_strobe_n(column_strobe_n),
    .write_enable_n(write_enable_n), .mem_addr(mem_addr), .mem_din(mem_din),
    .mem_dout(mem_dout));
  ////////////////////////////////////////
  // Clock at 8ns, row strobe release counter for page checks
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  always @(posedge row_strobe_n) ras_up++;
  task automatic close_out;
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // One request, held until taken; reads wait for the answer
  task automatic req(input drc_pkg::drc_op_t op, input logic [7:0] r, c, input logic w, p);
    int n;
    @(negedge clk_sys);
    req_op = op;
    {req_row, req_col, req_wdata, req_page} = {r, c, w, p};
    req_valid = 1'b1;
    for (n = 0; req_ready !== 1'b1 && n < 2000; n++) @(negedge clk_sys);
    if (n == 2000) num_errors++;
    @(negedge clk_sys);
    req_valid = 1'b0;
    if (op != drc_pkg::DRC_OP_WRITE) begin
      for (n = 0; rsp_valid !== 1'b1 && n < 200; n++) @(negedge clk_sys);
      rd = (rsp_valid === 1'b1) ? rsp_rdata : 1'bx;
    end
  endtask
  // Count row strobe falls before ready; waiting for the first high skips reset
  task automatic t_wake;
    logic prev;
    int   n;
    int   k;
    prev = 1'b0;
    k = 0;
    for (n = 0; init_done !== 1'b1 && n < 2000; n++) begin
      @(negedge clk_sys);
      if (!row_strobe_n && prev) k++;
      prev = row_strobe_n;
    end
    check(8'(k), 8'h08);
    check({6'h00, row_strobe_n, column_strobe_n}, 8'h03);
  endtask
  // Back to back writes to corner and pattern addresses, then read back
  task automatic t_rw;
    for (int i = 0; i < 4; i++) req(drc_pkg::DRC_OP_WRITE, ROWS[i], COLS[i], ~i[0], 1'b0);
    for (int i = 0; i < 4; i++) begin
      req(drc_pkg::DRC_OP_READ, ROWS[i], COLS[i], 1'b0, 1'b0);
      check({7'h00, rd}, {7'h00, ~i[0]});
    end
  endtask
  task automatic t_rmw;
    req(drc_pkg::DRC_OP_WRITE, 8'h33, 8'h44, 1'b1, 1'b0);
    req(drc_pkg::DRC_OP_RMW, 8'h33, 8'h44, 1'b0, 1'b0);
    check({7'h00, rd}, 8'h01);
    req(drc_pkg::DRC_OP_READ, 8'h33, 8'h44, 1'b0, 1'b0);
    check({7'h00, rd}, 8'h00);
  endtask
  // Open row, mixed column accesses, row must stay low until the last
  task automatic t_page;
    int u;
    req(drc_pkg::DRC_OP_WRITE, 8'h20, 8'h00, 1'b1, 1'b1);
    // Counted from here: the row of the earlier cycle closes after its answer
    u = ras_up;
    req(drc_pkg::DRC_OP_WRITE, 8'h20, 8'hff, 1'b0, 1'b1);
    req(drc_pkg::DRC_OP_RMW, 8'h20, 8'h00, 1'b0, 1'b1);
    check({7'h00, rd}, 8'h01);
    req(drc_pkg::DRC_OP_READ, 8'h20, 8'hff, 1'b1, 1'b1);
    check({7'h00, rd}, 8'h00);
    check(8'(ras_up - u), 8'h00);
    req(drc_pkg::DRC_OP_READ, 8'h20, 8'h00, 1'b0, 1'b0);
    check({7'h00, rd}, 8'h00);
  endtask
  // Two idle refreshes: row-only, consecutive 7-bit rows, data kept
  task automatic t_refresh;
    logic [7:0] a [2];
    logic       prev;
    int         n;
    int         k;
    prev = 1'b0;
    k = 0;
    for (n = 0; k < 2 && n < 3 * REFI; n++) begin
      @(negedge clk_sys);
      if (!row_strobe_n && prev) a[k++] = mem_addr;
      prev = row_strobe_n;
    end
    check({7'h00, column_strobe_n}, 8'h01);
    check(a[0] & 8'h80, 8'h00);
    check(a[1], (a[0] + 8'h01) & 8'h7f);
    req(drc_pkg::DRC_OP_READ, ROWS[2], COLS[2], 1'b0, 1'b0);
    check({7'h00, rd}, 8'h01);
  endtask
  initial begin
    rst_n = 1'b0;
    {req_valid, req_wdata, req_page, req_row, req_col} = 19'h0_0000;
    req_op = drc_pkg::DRC_OP_READ;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    t_wake();
    t_rw();
    t_rmw();
    t_page();
    t_refresh();
    close_out();
  end
  // Watchdog well past the few thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
